// ===== core/arc_trip_pkg.sv
package arc_trip_pkg;
    localparam int NZ = 4;
    localparam int NCH = 4;
    localparam int NSRC = 22;
    localparam int CLK_HZ = 10000000;
    localparam int STAMP_MS = 1;
    localparam int MS_CYCLES = CLK_HZ / 1000 * STAMP_MS;
    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFS_EVT_ON_EN = 8'h10;
    localparam logic [7:0] OFS_EVT_OFF_EN = 8'h14;
    localparam logic [7:0] OFS_CYC_DIV = 8'h18;
    localparam logic [7:0] OFS_LAST_CODE = 8'h1C;
    localparam logic [7:0] OFS_LAST_STAMP = 8'h20;
    localparam logic [7:0] OFS_LAST_DATA = 8'h24;
    localparam logic [3:0] ZCFG_PAGE = 4'h4;
    // Control bits.
    localparam int CTRL_ALLOW_LN = 0;
    localparam int CTRL_TEST = 1;
    localparam int CTRL_OFF = 2;
    // Zone configuration fields.
    localparam int CFG_EN = 0;
    localparam int CFG_PH = 1;
    localparam int CFG_RES = 2;
    localparam int CFG_LIGHT = 3;
    localparam int CFG_PRES = 7;
    localparam int CFG_DI = 11;
    typedef enum logic [1:0] {DI_OFF, DI_LIGHT, DI_CURRENT} di_mode_e;
    // Status source indices of the event stream.
    localparam int SRC_TRIP = 0;
    localparam int SRC_BLK = 4;
    localparam int SRC_START = 21;
    // Interrupt status bits.
    localparam int IRQ_TRIP = 0;
    localparam int IRQ_BLOCK = 1;
    localparam int IRQ_EVT = 2;
    // Codes and reset values.
    localparam logic [5:0] IDX_NONE = 6'h3F;
    localparam logic [3:0] CODE_NONE = 4'hF;
    localparam logic [2:0] BEH_HIDDEN = 3'h0;
    localparam logic [2:0] BEH_ON = 3'h1;
    localparam logic [2:0] BEH_BLOCKED = 3'h2;
    localparam logic [2:0] BEH_TEST = 3'h3;
    localparam logic [2:0] BEH_TEST_BLK = 3'h4;
    localparam logic [2:0] BEH_OFF = 3'h5;
    localparam logic [15:0] CYC_DIV_RST = 16'h03E7;
    localparam logic [21:0] EVT_EN_RST = 22'h3FFFFF;
endpackage

// ===== core/arc_zone_trip.sv
`timescale 1ns/100ps
// Summary of operation
// - Blocking input sampled once per program cycle.
// - New pick-up, unblocked: zone trips.
// - New pick-up, blocked: blocked indication, no trip.
// - Blocking raises display and stamped blocking event.
// - Every status change makes event and entry; here only changes of enabled event sources do, not of the code fields.
// - Per-event choice stores ON, OFF or both.
// - Events carry time stamp and process data.
// - Condition code: 2z trip, 2z+1 blocked.
// - Behaviour code 1..5, shown only when allowed.
// - Sensor status code 0..3 for current elements.
// - Current elements give start/blocked ON/OFF events.
// - Channels give light/pressure ON/OFF events.
// - Zone pick-up from its enabled sources.
// - Current-in needs input plus sensor; light-in alone.
module arc_zone_trip #(
    parameter int MS_CYCLES = arc_trip_pkg::MS_CYCLES
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Pick-up and sensor pins
    input wire logic PH_PICKUP,
    input wire logic RES_PICKUP,
    input wire logic [3:0] LIGHT,
    input wire logic [3:0] PRESSURE,
    input wire logic DI_IN,
    input wire logic BLOCK_IN,
    // Process data from the measurement path
    input wire logic [31:0] PROC_DATA,
    // Zone status
    output logic [3:0] ZONE_TRIP,
    output logic [3:0] ZONE_BLOCKED,
    output logic FUNC_START,
    // Blocking report
    output logic DISP_EVT,
    output logic BLK_EVT,
    output logic [3:0] BLK_ZONES,
    output logic [31:0] BLK_CURRENT,
    output logic [31:0] BLK_STAMP,
    // Event stream to the event buffer
    output logic EVT_VALID,
    input wire logic EVT_READY,
    output logic [5:0] EVT_CODE,
    output logic [31:0] EVT_STAMP,
    output logic [31:0] EVT_DATA,
    // Interrupt
    output logic IRQ
);
    localparam logic [13:0] MS_LAST = 14'(MS_CYCLES - 1);

    function automatic logic [5:0] first_set(input logic [31:0] v);
        logic [5:0] r;
        r = arc_trip_pkg::IDX_NONE;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                r = 6'(i);
            end
        end
        return r;
    endfunction

    logic [11:0] pin_meta_q;
    logic [11:0] pin_sync_q;
    logic [15:0] cyc_cnt_q;
    logic [15:0] cyc_div_q;
    logic tick_q;
    logic [13:0] ms_cnt_q;
    logic [31:0] stamp_q;
    logic [2:0] ctrl_q;
    logic [12:0] zone_cfg_q [4];
    logic [3:0] pick_q;
    logic [3:0] trip_q;
    logic [3:0] blocked_q;
    logic blk_q;
    logic start_q;
    logic ph_st_q, ph_blk_q, res_st_q, res_blk_q;
    logic [3:0] cond_q;
    logic [3:0] sens_q;
    logic [2:0] beh_q;
    logic disp_q, blk_evt_q;
    logic [3:0] blk_zones_q;
    logic [31:0] blk_cur_q, blk_stamp_q;
    logic [21:0] src_prev_q, pend_on_q, pend_off_q, on_en_q, off_en_q;
    logic evt_valid_q;
    logic [5:0] evt_code_q;
    logic [31:0] evt_stamp_q, evt_data_q;
    logic [5:0] last_code_q;
    logic [31:0] last_stamp_q, last_data_q;
    logic [2:0] irq_stat_q, irq_mask_q;
    logic irq_q;
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            pin_meta_q <= 12'h000;
            pin_sync_q <= 12'h000;
        end else begin
            pin_meta_q <= {BLOCK_IN, DI_IN, PRESSURE, LIGHT, RES_PICKUP, PH_PICKUP};
            pin_sync_q <= pin_meta_q;
        end
    end

    wire ph_s = pin_sync_q[0];
    wire res_s = pin_sync_q[1];
    wire [3:0] light_s = pin_sync_q[5:2];
    wire [3:0] pres_s = pin_sync_q[9:6];
    wire di_s = pin_sync_q[10];
    // The blocker must lead the operating delay by 5 ms; one that arrives after the pick-up tick never undoes the trip.
    wire blk_s = pin_sync_q[11];

    // Program cycle lasts CYC_DIV+1 clocks; tick_q is its one-cycle start pulse.
    wire cyc_end = cyc_cnt_q >= cyc_div_q;
    wire ms_end = ms_cnt_q == MS_LAST;
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            cyc_cnt_q <= 16'h0000;
            tick_q <= 1'b0;
            ms_cnt_q <= 14'h0000;
            stamp_q <= 32'h00000000;
        end else begin
            cyc_cnt_q <= cyc_end ? 16'h0000 : cyc_cnt_q + 16'h0001;
            tick_q <= cyc_end;
            ms_cnt_q <= ms_end ? 14'h0000 : ms_cnt_q + 14'h0001;
            stamp_q <= ms_end ? stamp_q + 32'h00000001 : stamp_q;
        end
    end

    wire func_off = ctrl_q[arc_trip_pkg::CTRL_OFF];
    wire [3:0] pick;
    wire [7:0] zone_pair;
    wire [11:0] sens_vec;
    assign sens_vec[3:0] = {res_st_q, res_blk_q, ph_st_q, ph_blk_q};

    for (genvar z = 0; z < 4; z++) begin : g_zone
        wire [12:0] cfg = zone_cfg_q[z];
        arc_trip_pkg::di_mode_e dm;
        assign dm = arc_trip_pkg::di_mode_e'(cfg[arc_trip_pkg::CFG_DI +: 2]);
        wire ph_en = cfg[arc_trip_pkg::CFG_PH];
        wire res_en = cfg[arc_trip_pkg::CFG_RES];
        wire sens = |(light_s & cfg[arc_trip_pkg::CFG_LIGHT +: 4])
                  | |(pres_s & cfg[arc_trip_pkg::CFG_PRES +: 4]);
        wire cur_ok = !(ph_en | res_en) | (ph_en & ph_s) | (res_en & res_s);
        wire trig = (dm == arc_trip_pkg::DI_CURRENT) ? (di_s & sens)
                  : (sens | ((dm == arc_trip_pkg::DI_LIGHT) & di_s));
        assign pick[z] = cfg[arc_trip_pkg::CFG_EN] & !func_off & cur_ok & trig;
        assign zone_pair[2*z] = trip_q[z];
        assign zone_pair[2*z+1] = blocked_q[z];
        assign sens_vec[4+2*z] = light_s[z];
        assign sens_vec[5+2*z] = pres_s[z];
    end

    wire [3:0] rise = pick & ~pick_q;
    wire [3:0] new_trip = rise & {4{!blk_s}};
    wire [3:0] new_blk = rise & {4{blk_s}};

    // Decisions latch until pick-up drops, so a blocked fault is never re-judged.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            pick_q <= 4'h0;
            trip_q <= 4'h0;
            blocked_q <= 4'h0;
            blk_q <= 1'b0;
            start_q <= 1'b0;
            {ph_st_q, ph_blk_q, res_st_q, res_blk_q} <= 4'h0;
        end else if (tick_q) begin
            blk_q <= blk_s;
            pick_q <= pick;
            start_q <= |pick;
            trip_q <= (trip_q & pick) | new_trip;
            blocked_q <= (blocked_q & pick) | new_blk;
            ph_st_q <= ph_s & !blk_s;
            ph_blk_q <= ph_s & blk_s;
            res_st_q <= res_s & !blk_s;
            res_blk_q <= res_s & blk_s;
        end
    end

    AST_BLK_SAMPLE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        !tick_q |=> $stable(blk_q)) else $error("blocking sample moved mid-cycle");
    AST_TRIP_UNBLOCKED: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $rose(trip_q[0]) |-> !blk_q && $past(tick_q)) else $error("trip while blocked");
    AST_BLOCKED_CAUSE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $rose(blocked_q[1]) |-> blk_q) else $error("blocked without blocker");
    AST_EXCLUSIVE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (trip_q & blocked_q) == 4'h0) else $error("zone both tripped and blocked");

    wire [5:0] cond_idx = first_set({24'h000000, zone_pair});
    wire [5:0] sens_idx = first_set({20'h00000, sens_vec});
    wire test_m = ctrl_q[arc_trip_pkg::CTRL_TEST];
    wire [2:0] beh_d = !ctrl_q[arc_trip_pkg::CTRL_ALLOW_LN] ? arc_trip_pkg::BEH_HIDDEN
                     : func_off ? arc_trip_pkg::BEH_OFF
                     : (test_m & blk_q) ? arc_trip_pkg::BEH_TEST_BLK
                     : test_m ? arc_trip_pkg::BEH_TEST
                     : blk_q ? arc_trip_pkg::BEH_BLOCKED
                     : arc_trip_pkg::BEH_ON;

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            cond_q <= arc_trip_pkg::CODE_NONE;
            sens_q <= arc_trip_pkg::CODE_NONE;
            beh_q <= arc_trip_pkg::BEH_HIDDEN;
            disp_q <= 1'b0;
            blk_evt_q <= 1'b0;
            blk_zones_q <= 4'h0;
            blk_cur_q <= 32'h00000000;
            blk_stamp_q <= 32'h00000000;
        end else begin
            cond_q <= (cond_idx == arc_trip_pkg::IDX_NONE) ? arc_trip_pkg::CODE_NONE
                    : cond_idx[3:0];
            sens_q <= (sens_idx == arc_trip_pkg::IDX_NONE) ? arc_trip_pkg::CODE_NONE
                    : sens_idx[3:0];
            beh_q <= beh_d;
            disp_q <= tick_q & |new_blk;
            blk_evt_q <= tick_q & |new_blk;
            if (tick_q & |new_blk) begin
                blk_zones_q <= new_blk;
                blk_cur_q <= PROC_DATA;
                blk_stamp_q <= stamp_q;
            end
        end
    end

    AST_DISP_ON_BLOCK: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $rose(blocked_q[2]) |-> disp_q && blk_evt_q && blk_zones_q[2]) else $error("no block report");
    AST_COND_Z1: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        trip_q[0] |=> cond_q == 4'h0) else $error("condition code not zone one trip");
    AST_BEH_HIDDEN: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        ##1 (!$past(ctrl_q[0]) |-> beh_q == 3'h0)) else $error("behaviour shown while hidden");
    AST_SENS_PH_BLK: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        ph_blk_q |=> sens_q == 4'h0) else $error("sensor code not phase blocked");

    // Sources: zone trips/blocks, current elements, channels, digital input, start.
    wire [21:0] src = {start_q, di_s, pres_s, light_s, res_st_q, res_blk_q,
                       ph_st_q, ph_blk_q, blocked_q, trip_q};
    wire [21:0] chg_on = src & ~src_prev_q & on_en_q;
    wire [21:0] chg_off = ~src & src_prev_q & off_en_q;
    wire [5:0] on_pick = first_set({10'h000, pend_on_q});
    wire [5:0] off_pick = first_set({10'h000, pend_off_q});
    wire have_on = on_pick != arc_trip_pkg::IDX_NONE;
    wire have_off = off_pick != arc_trip_pkg::IDX_NONE;
    wire [4:0] sel_idx = have_on ? on_pick[4:0] : off_pick[4:0];
    wire load = (!evt_valid_q | EVT_READY) & (have_on | have_off);
    wire [21:0] sel_mask = 22'(22'h000001 << sel_idx);
    wire [21:0] clr_on = (load & have_on) ? sel_mask : 22'h000000;
    wire [21:0] clr_off = (load & !have_on) ? sel_mask : 22'h000000;

    // One pending bit per transition: while the buffer stalls, a source that toggles
    // repeatedly yields one ON and one OFF, and ON goes out first.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            src_prev_q <= 22'h000000;
            pend_on_q <= 22'h000000;
            pend_off_q <= 22'h000000;
            evt_valid_q <= 1'b0;
            evt_code_q <= 6'h00;
            evt_stamp_q <= 32'h00000000;
            evt_data_q <= 32'h00000000;
            last_code_q <= 6'h00;
            last_stamp_q <= 32'h00000000;
            last_data_q <= 32'h00000000;
        end else begin
            src_prev_q <= src;
            pend_on_q <= (pend_on_q & ~clr_on) | chg_on;
            pend_off_q <= (pend_off_q & ~clr_off) | chg_off;
            evt_valid_q <= load | (evt_valid_q & !EVT_READY);
            if (load) begin
                evt_code_q <= {sel_idx, have_on};
                evt_stamp_q <= stamp_q;
                evt_data_q <= PROC_DATA;
                last_code_q <= {sel_idx, have_on};
                last_stamp_q <= stamp_q;
                last_data_q <= PROC_DATA;
            end
        end
    end

    AST_EVT_HOLD: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        evt_valid_q && !EVT_READY |=> evt_valid_q && $stable(evt_code_q)
        && $stable(evt_stamp_q)) else $error("event dropped under stall");
    AST_ZONE_TRIP_EVT: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $rose(trip_q[0]) && on_en_q[0] && !EVT_VALID |=> ##[0:1] evt_valid_q)
        else $error("zone trip change gave no event");
    AST_EVT_SELECT: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        !on_en_q[3] && !pend_on_q[3] |=> !pend_on_q[3]) else $error("deselected ON pended");

    // APB: one wait state, read data and error are captured on the same edge that PREADY rises.
    wire zcfg_hit = PADDR[7:4] == arc_trip_pkg::ZCFG_PAGE;
    wire [1:0] zi = PADDR[3:2];
    wire aligned = PADDR[1:0] == 2'h0;
    wire reg_hit = aligned & (zcfg_hit | (PADDR <= arc_trip_pkg::OFS_LAST_DATA));
    wire acc = PSEL & PENABLE & pready_q;
    wire wr = acc & PWRITE & reg_hit;
    wire [31:0] status_word = {8'h00, 1'b0, beh_q, sens_q, cond_q, 3'h0, start_q,
                               blocked_q, trip_q};
    wire [2:0] irq_set = {load, tick_q & |new_blk, tick_q & |new_trip};
    wire [2:0] irq_w1c = (wr && PADDR == arc_trip_pkg::OFS_IRQ_STAT) ? PWDATA[2:0] : 3'h0;
    wire [2:0] irq_stat_d = (irq_stat_q & ~irq_w1c) | irq_set;
    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = 32'h00000000;
        if (zcfg_hit) begin
            rdata_d = {19'h00000, zone_cfg_q[zi]};
        end else begin
            unique case (PADDR)
                arc_trip_pkg::OFS_CTRL: rdata_d = {29'h00000000, ctrl_q};
                arc_trip_pkg::OFS_STATUS: rdata_d = status_word;
                arc_trip_pkg::OFS_IRQ_STAT: rdata_d = {29'h00000000, irq_stat_q};
                arc_trip_pkg::OFS_IRQ_MASK: rdata_d = {29'h00000000, irq_mask_q};
                arc_trip_pkg::OFS_EVT_ON_EN: rdata_d = {10'h000, on_en_q};
                arc_trip_pkg::OFS_EVT_OFF_EN: rdata_d = {10'h000, off_en_q};
                arc_trip_pkg::OFS_CYC_DIV: rdata_d = {16'h0000, cyc_div_q};
                arc_trip_pkg::OFS_LAST_CODE: rdata_d = {26'h0000000, last_code_q};
                arc_trip_pkg::OFS_LAST_STAMP: rdata_d = last_stamp_q;
                arc_trip_pkg::OFS_LAST_DATA: rdata_d = last_data_q;
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= PSEL & PENABLE & !pready_q;
            if (PSEL & PENABLE & !pready_q) begin
                prdata_q <= PWRITE ? 32'h00000000 : rdata_d;
                pslverr_q <= !reg_hit;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            ctrl_q <= 3'h0;
            irq_stat_q <= 3'h0;
            irq_mask_q <= 3'h0;
            irq_q <= 1'b0;
            on_en_q <= arc_trip_pkg::EVT_EN_RST;
            off_en_q <= arc_trip_pkg::EVT_EN_RST;
            cyc_div_q <= arc_trip_pkg::CYC_DIV_RST;
            for (int i = 0; i < 4; i++) begin
                zone_cfg_q[i] <= 13'h0000;
            end
        end else begin
            irq_stat_q <= irq_stat_d;
            irq_q <= |(irq_stat_d & irq_mask_q);
            if (wr && zcfg_hit) begin
                zone_cfg_q[zi] <= PWDATA[12:0];
            end
            if (wr && PADDR == arc_trip_pkg::OFS_CTRL) begin
                ctrl_q <= PWDATA[2:0];
            end
            if (wr && PADDR == arc_trip_pkg::OFS_IRQ_MASK) begin
                irq_mask_q <= PWDATA[2:0];
            end
            if (wr && PADDR == arc_trip_pkg::OFS_EVT_ON_EN) begin
                on_en_q <= PWDATA[21:0];
            end
            if (wr && PADDR == arc_trip_pkg::OFS_EVT_OFF_EN) begin
                off_en_q <= PWDATA[21:0];
            end
            if (wr && PADDR == arc_trip_pkg::OFS_CYC_DIV) begin
                cyc_div_q <= PWDATA[15:0];
            end
        end
    end

    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign ZONE_TRIP = trip_q;
    assign ZONE_BLOCKED = blocked_q;
    assign FUNC_START = start_q;
    assign DISP_EVT = disp_q;
    assign BLK_EVT = blk_evt_q;
    assign BLK_ZONES = blk_zones_q;
    assign BLK_CURRENT = blk_cur_q;
    assign BLK_STAMP = blk_stamp_q;
    assign EVT_VALID = evt_valid_q;
    assign EVT_CODE = evt_code_q;
    assign EVT_STAMP = evt_stamp_q;
    assign EVT_DATA = evt_data_q;
    assign IRQ = irq_q;
endmodule

// ===== verification/evt_sink.sv
`timescale 1ns/100ps
// Event buffer on the far side; in slow mode it accepts only every other cycle.
module evt_sink (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Event stream
    input wire logic valid,
    input wire logic [5:0] code,
    output logic ready,
    // Control and record of codes taken
    input wire logic slow,
    input wire logic clr,
    output logic [63:0] seen
);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ready <= 1'b0;
            seen <= 64'h0;
        end else begin
            ready <= slow ? ~ready : 1'b1;
            if (clr) begin
                seen <= 64'h0;
            end else if (valid && ready) begin
                seen[code] <= 1'b1;
            end
        end
    end
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic SYS_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR;
    logic PH_PICKUP = 1'b0;
    logic RES_PICKUP = 1'b0;
    logic [3:0] LIGHT = 4'h0;
    logic [3:0] PRESSURE = 4'h0;
    logic DI_IN = 1'b0;
    logic BLOCK_IN = 1'b0;
    logic [31:0] PROC_DATA = 32'h0000ABCD;
    logic [3:0] ZONE_TRIP, ZONE_BLOCKED, BLK_ZONES;
    logic FUNC_START, DISP_EVT, BLK_EVT, EVT_VALID, EVT_READY, IRQ;
    logic [31:0] BLK_CURRENT, BLK_STAMP, EVT_STAMP, EVT_DATA;
    logic [5:0] EVT_CODE;
    logic slow = 1'b0;
    logic clr = 1'b0;
    logic [63:0] seen;
    logic [31:0] rd;
    logic er;
    int err_count = 0;
    int check_count = 0;
    int disp_n = 0;
    int blk_n = 0;
    logic [2:0] ctl_v[6] = '{3'h1, 3'h1, 3'h3, 3'h3, 3'h5, 3'h0};
    logic blk_v[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    logic [2:0] beh_v[6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0};

    always #50 SYS_CLK = ~SYS_CLK;

    arc_zone_trip #(.MS_CYCLES(10)) arc_zone_trip_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PH_PICKUP(PH_PICKUP),
        .RES_PICKUP(RES_PICKUP), .LIGHT(LIGHT), .PRESSURE(PRESSURE), .DI_IN(DI_IN),
        .BLOCK_IN(BLOCK_IN), .PROC_DATA(PROC_DATA), .ZONE_TRIP(ZONE_TRIP),
        .ZONE_BLOCKED(ZONE_BLOCKED), .FUNC_START(FUNC_START), .DISP_EVT(DISP_EVT),
        .BLK_EVT(BLK_EVT), .BLK_ZONES(BLK_ZONES), .BLK_CURRENT(BLK_CURRENT),
        .BLK_STAMP(BLK_STAMP), .EVT_VALID(EVT_VALID), .EVT_READY(EVT_READY),
        .EVT_CODE(EVT_CODE), .EVT_STAMP(EVT_STAMP), .EVT_DATA(EVT_DATA), .IRQ(IRQ));

    evt_sink evt_sink_i (.clk(SYS_CLK), .rst_n(RST_N), .valid(EVT_VALID), .code(EVT_CODE),
        .ready(EVT_READY), .slow(slow), .clr(clr), .seen(seen));

    always @(posedge SYS_CLK) begin
        disp_n += (DISP_EVT === 1'b1);
        blk_n += (BLK_EVT === 1'b1);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        err_count += (n >= 20);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // Sync flops plus one four-clock program cycle fit well inside twelve clocks.
    task automatic settle();
        repeat (12) @(posedge SYS_CLK);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge SYS_CLK);
        err_count++;
        give_verdict();
    end

    initial begin
        repeat (8) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        rdc(arc_trip_pkg::OFS_STATUS, 32'h000FF000);
        rdc(arc_trip_pkg::OFS_EVT_ON_EN, 32'h003FFFFF);
        apb(1'b0, 8'h30, 32'h0);
        chk({31'h0, er}, 32'h1);
        $display("reset test done");
        apb(1'b1, arc_trip_pkg::OFS_CYC_DIV, 32'h3);
        apb(1'b1, arc_trip_pkg::OFS_EVT_OFF_EN, 32'h003FFFFE);
        apb(1'b1, 8'h40, 32'h9);
        apb(1'b1, 8'h44, 32'h11);
        apb(1'b1, 8'h48, 32'h1021);
        apb(1'b1, 8'h4C, 32'h801);
        slow <= 1'b1;
        LIGHT <= 4'h1;
        settle();
        chk({28'h0, ZONE_TRIP}, 32'h1);
        chk({28'h0, ZONE_BLOCKED}, 32'h0);
        chk({31'h0, FUNC_START}, 32'h1);
        rdc(arc_trip_pkg::OFS_STATUS, 32'h00040101);
        chk({31'h0, IRQ}, 32'h0);
        apb(1'b1, arc_trip_pkg::OFS_IRQ_MASK, 32'h1);
        repeat (3) @(posedge SYS_CLK);
        chk({31'h0, IRQ}, 32'h1);
        apb(1'b1, arc_trip_pkg::OFS_IRQ_STAT, 32'h1);
        repeat (3) @(posedge SYS_CLK);
        chk({31'h0, IRQ}, 32'h0);
        LIGHT <= 4'h0;
        settle();
        repeat (40) @(posedge SYS_CLK);
        chk({31'h0, seen[6'h01]}, 32'h1);
        chk({31'h0, seen[6'h00]}, 32'h0);
        chk({30'h0, seen[6'h19], seen[6'h18]}, 32'h3);
        chk({31'h0, seen[6'h2B]}, 32'h1);
        rdc(arc_trip_pkg::OFS_LAST_DATA, 32'h0000ABCD);
        $display("trip test done");
        clr <= 1'b1;
        BLOCK_IN <= 1'b1;
        @(posedge SYS_CLK);
        clr <= 1'b0;
        settle();
        LIGHT <= 4'h2;
        settle();
        chk({24'h0, ZONE_BLOCKED, ZONE_TRIP}, 32'h20);
        chk({28'h0, BLK_ZONES}, 32'h2);
        chk(BLK_CURRENT, 32'h0000ABCD);
        chk(disp_n + blk_n, 32'h2);
        rdc(arc_trip_pkg::OFS_STATUS, 32'h00063120);
        BLOCK_IN <= 1'b0;
        settle();
        chk({24'h0, ZONE_BLOCKED, ZONE_TRIP}, 32'h20);
        LIGHT <= 4'h0;
        settle();
        repeat (40) @(posedge SYS_CLK);
        chk({30'h0, seen[6'h0B], seen[6'h0A]}, 32'h3);
        chk({31'h0, FUNC_START}, 32'h0);
        $display("block test done");
        LIGHT <= 4'h4;
        settle();
        chk({28'h0, ZONE_TRIP}, 32'h0);
        DI_IN <= 1'b1;
        settle();
        chk({28'h0, ZONE_TRIP}, 32'hC);
        LIGHT <= 4'h0;
        DI_IN <= 1'b0;
        settle();
        $display("input mode test done");
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, arc_trip_pkg::OFS_CTRL, {29'h0, ctl_v[i]});
            BLOCK_IN <= blk_v[i];
            settle();
            apb(1'b0, arc_trip_pkg::OFS_STATUS, 32'h0);
            chk({29'h0, rd[22:20]}, {29'h0, beh_v[i]});
        end
        $display("behaviour test done");
        give_verdict();
    end
endmodule
